//--- uhc_pkg.sv
// constants shared by the usb host clock and transceiver sharing glue
package uhc_pkg;
    // register bus geometry
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;

    // register offsets (byte addresses, one word each)
    localparam logic [7:0] OFF_CTRL   = 8'h00;
    localparam logic [7:0] OFF_STATUS = 8'h04;

    // control register field positions
    localparam int CTRL_PERIPH_EN  = 0;
    localparam int CTRL_PLL_EN     = 1;
    localparam int CTRL_BIAS_EN    = 2;
    localparam int CTRL_SRC_UTMI   = 3;
    localparam int CTRL_OHCI_EN    = 4;
    localparam int CTRL_DEV_PORT   = 5;
    localparam int CTRL_DIV_LSB    = 8;
    localparam int DIV_W           = 4;
    localparam int CTRL_COUNT_LSB  = 16;
    localparam int COUNT_W         = 8;

    // status register field positions
    localparam int STAT_LOCKED     = 0;
    localparam int STAT_HS_READY   = 1;
    localparam int STAT_OHCI_RUN   = 2;
    localparam int STAT_DEV_OWNS   = 3;
    localparam int STAT_UNRECOV    = 4;
    localparam int STAT_SWITCHING  = 5;

    // reset values
    localparam logic [31:0] CTRL_RESET = 32'h0000_0000;

    // clock figures
    localparam int UTMI_PLL_MHZ    = 480;
    localparam int HS_IF_MHZ       = 30;
    localparam int OHCI_FAST_MHZ   = 48;
    localparam int OHCI_SLOW_MHZ   = 12;
    localparam int SLOW_RATIO      = 4;
    localparam logic [3:0] UTMI_DIV_SETTING = 4'h9;   // divide by ten from the utmi pll
    localparam int FS_MAX_DEVICES  = 127;

    // quiet time around a clock-source or owner switch
    localparam int CLK_PERIOD_NS   = 10;
    localparam int SWITCH_QUIET_NS = 100;
    localparam int SWITCH_QUIET_CYC =
        (SWITCH_QUIET_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int QUIET_W = 4;

    typedef enum logic [1:0] {GATE_STOPPED, GATE_QUIET, GATE_RUN} uhc_gate_t;
endpackage

//--- uhc_clk_if.sv
// carrier between the clock gate and the ohci divider
`timescale 1ns/10ps
`default_nettype none
interface uhc_clk_if;
    import uhc_pkg::*;
    logic             srcTick;   // one pulse per source clock period
    logic [DIV_W-1:0] divider;   // divide by divider+1
    logic             run;       // divider may produce ticks
    logic             tick48;    // fast ohci enable
    logic             tick12;    // slow ohci enable
    modport ctl (output srcTick, output divider, output run, input tick48, input tick12);
    modport gen (input srcTick, input divider, input run, output tick48, output tick12);
endinterface
`default_nettype wire

//--- uhc_ohci_div.sv
// divider that makes the fast and slow ohci clock enables
`timescale 1ns/10ps
`default_nettype none
module uhc_ohci_div (
    // clock and reset
    input  wire logic clk_sys,
    input  wire logic reset,
    // link to the clock gate
    uhc_clk_if.gen    clk
);
    import uhc_pkg::*;

    logic [DIV_W-1:0] cnt;
    logic [1:0]       quarter;
    logic             t48;
    logic             t12;
    logic [DIV_W-1:0] next_cnt;
    logic [1:0]       next_quarter;
    logic             next_t48;
    logic             next_t12;

    // ------------------------------------------------------------
    // divide source ticks, then the fast enable by four
    // ------------------------------------------------------------
    // stopped divider holds zero so a restart begins with a full period
    always_comb begin
        next_cnt     = cnt;
        next_quarter = quarter;
        next_t48     = 1'b0;
        next_t12     = 1'b0;
        if (!clk.run) begin
            next_cnt     = '0;
            next_quarter = '0;
        end else if (clk.srcTick) begin
            if (cnt == clk.divider) begin
                next_cnt     = '0;
                next_t48     = 1'b1;
                next_quarter = quarter + 2'd1;
                next_t12     = (quarter == 2'(SLOW_RATIO - 1));
            end else begin
                next_cnt = cnt + DIV_W'(1);
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            cnt     <= '0;
            quarter <= '0;
            t48     <= 1'b0;
            t12     <= 1'b0;
        end else begin
            cnt     <= next_cnt;
            quarter <= next_quarter;
            t48     <= next_t48;
            t12     <= next_t12;
        end
    end

    assign clk.tick48 = t48;
    assign clk.tick12 = t12;
endmodule
`default_nettype wire

//--- uhc_clock_phy_share.sv
// clock gating, ohci clock generation and shared port-a transceiver routing
//
// How it works
// - host line pins come only from host or device controller logic through transceivers, no gpio path.
// - device_port_enable set gives the shared transceiver to the device controller.
// - with it clear, host port a line outputs drive the shared transceiver.
// - host high-speed path runs only while the utmi pll is enabled and locked; device hs lines pass regardless.
// - ohci keeps running on the system pll when the utmi pll stops.
// - the transceiver's returned 30 MHz tick is the high-speed interface enable.
// - ohci 48 and 12 MHz enables come from the chosen pll through the divider.
// - the 12 MHz enable is the 48 MHz enable divided by four.
// - one interrupt line leaves the host; interrupt controller is set up first.
// - full-speed ports run half duplex at 12 Mbit/s, up to 127 devices.
// - bus-master memory errors raise a sticky unrecoverable error flag.
`timescale 1ns/10ps
`default_nettype none
module uhc_clock_phy_share (
    // clock and reset
    input  wire logic                        clk_sys,
    input  wire logic                        reset,
    // register port
    input  wire logic [uhc_pkg::ADDR_W-1:0]  regAddr,
    input  wire logic [uhc_pkg::DATA_W-1:0]  regWdata,
    input  wire logic                        regWrite,
    input  wire logic                        regRead,
    output logic      [uhc_pkg::DATA_W-1:0]  regRdata,
    // pll side
    input  wire logic                        utmiPllLockPin,
    input  wire logic                        utmiPllTick,
    input  wire logic                        systemPllTick,
    output logic                             utmiPllEnable,
    output logic                             phyBiasEnable,
    output logic      [uhc_pkg::COUNT_W-1:0] pllStartupCount,
    // clock enables toward the host controller
    input  wire logic                        phyClk30Tick,
    output logic                             hsIfTick,
    output logic                             ohci48mTick,
    output logic                             ohci12mTick,
    output logic                             hostPeriphClkEn,
    // host events
    input  wire logic                        ehciIrq,
    input  wire logic                        ohciIrq,
    input  wire logic                        hostBusError,
    output logic                             hostIrq,
    // line drivers of both controllers, {dminus, dplus}
    input  wire logic [1:0]                  hostAFsLine,
    input  wire logic [1:0]                  hostAHsLine,
    input  wire logic [1:0]                  deviceFsLine,
    input  wire logic [1:0]                  deviceHsLine,
    input  wire logic                        hostADrive,
    input  wire logic                        deviceDrive,
    // shared port-a transceiver
    output logic      [1:0]                  xcvrFsOut,
    output logic      [1:0]                  xcvrHsOut,
    output logic                             xcvrOe_n,
    output logic                             deviceOwnsPort
);
    import uhc_pkg::*;

    function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [7:0] off);
        hit = (a == off);
    endfunction

    // ------------------------------------------------------------
    // registers and status
    // ------------------------------------------------------------
    logic [31:0] ctrl;
    logic        unrecov;
    logic [31:0] next_ctrl;
    logic        next_unrecov;
    logic [31:0] next_rdata;
    logic [2:0]  lockSync;
    logic        locked;
    logic        next_locked;
    logic        hsReady;
    logic        switching;
    uhc_gate_t   gate;

    logic             periphEn;
    logic             pllEn;
    logic             phy_bias_enable;
    logic             srcUtmi;
    logic             ohciEn;
    logic             devPort;
    logic [DIV_W-1:0] divSet;

    assign periphEn = ctrl[CTRL_PERIPH_EN];
    assign pllEn    = ctrl[CTRL_PLL_EN];
    assign phy_bias_enable   = ctrl[CTRL_BIAS_EN];
    assign srcUtmi  = ctrl[CTRL_SRC_UTMI];
    assign ohciEn   = ctrl[CTRL_OHCI_EN];
    assign devPort  = ctrl[CTRL_DEV_PORT];
    assign divSet   = ctrl[CTRL_DIV_LSB +: DIV_W];

    // lock changes count once the second and third stages agree
    always_comb begin
        next_locked = (lockSync[1] == lockSync[2]) ? lockSync[2] : locked;
    end

    // high-speed use needs clock, running locked pll and bias
    assign hsReady = periphEn & pllEn & locked & phy_bias_enable;

    // writes land the cycle after the strobe; reads answer one cycle later
    always_comb begin
        next_ctrl    = ctrl;
        next_unrecov = unrecov;
        next_rdata   = '0;
        if (regWrite && hit(regAddr, OFF_CTRL)) begin
            next_ctrl = regWdata;
        end
        if (regWrite && hit(regAddr, OFF_STATUS) && regWdata[STAT_UNRECOV]) begin
            next_unrecov = 1'b0;
        end
        if (hostBusError) begin
            next_unrecov = 1'b1;
        end
        if (regRead && hit(regAddr, OFF_CTRL)) begin
            next_rdata = ctrl & 32'h00FF_0F3F;
        end else if (regRead && hit(regAddr, OFF_STATUS)) begin
            next_rdata[STAT_LOCKED]    = locked;
            next_rdata[STAT_HS_READY]  = hsReady;
            next_rdata[STAT_OHCI_RUN]  = (gate == GATE_RUN);
            next_rdata[STAT_DEV_OWNS]  = deviceOwnsPort;
            next_rdata[STAT_UNRECOV]   = unrecov;
            next_rdata[STAT_SWITCHING] = switching;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            ctrl     <= CTRL_RESET;
            unrecov  <= 1'b0;
            regRdata <= '0;
            lockSync <= '0;
            locked   <= 1'b0;
        end else begin
            ctrl     <= next_ctrl;
            unrecov  <= next_unrecov;
            regRdata <= next_rdata;
            lockSync <= {lockSync[1:0], utmiPllLockPin};
            locked   <= next_locked;
        end
    end

    // ------------------------------------------------------------
    // ohci clock source gate
    // ------------------------------------------------------------
    // any change of source or divider stops the enables, waits, restarts
    uhc_clk_if clkLink ();
    uhc_gate_t          next_gate;
    logic [QUIET_W-1:0] gateCnt;
    logic [QUIET_W-1:0] next_gateCnt;
    logic [DIV_W:0]     cfgSeen;
    logic [DIV_W:0]     next_cfgSeen;
    logic               srcOk;
    logic               want;

    // the utmi source is usable only with its pll locked; system pll always
    assign srcOk = srcUtmi ? (pllEn & locked) : 1'b1;
    assign want  = periphEn & ohciEn & srcOk;

    always_comb begin
        next_gate    = gate;
        next_gateCnt = gateCnt;
        next_cfgSeen = {srcUtmi, divSet};
        unique case (gate)
            GATE_STOPPED: begin
                if (want) begin
                    next_gate    = GATE_QUIET;
                    next_gateCnt = '0;
                end
            end
            GATE_QUIET: begin
                if (!want || cfgSeen != {srcUtmi, divSet}) begin
                    next_gateCnt = '0;
                    if (!want) next_gate = GATE_STOPPED;
                end else if (gateCnt == QUIET_W'(SWITCH_QUIET_CYC - 1)) begin
                    next_gate = GATE_RUN;
                end else begin
                    next_gateCnt = gateCnt + QUIET_W'(1);
                end
            end
            GATE_RUN: begin
                if (!want) begin
                    next_gate = GATE_STOPPED;
                end else if (cfgSeen != {srcUtmi, divSet}) begin
                    next_gate    = GATE_QUIET;
                    next_gateCnt = '0;
                end
            end
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            gate    <= GATE_STOPPED;
            gateCnt <= '0;
            cfgSeen <= '0;
        end else begin
            gate    <= next_gate;
            gateCnt <= next_gateCnt;
            cfgSeen <= next_cfgSeen;
        end
    end

    // chosen pll tick feeds the divider
    assign clkLink.srcTick = srcUtmi ? (utmiPllTick & pllEn & locked) : systemPllTick;
    assign clkLink.divider = divSet;
    assign clkLink.run     = (gate == GATE_RUN);

    uhc_ohci_div divider (
        .clk_sys (clk_sys),
        .reset   (reset),
        .clk     (clkLink)
    );

    // ------------------------------------------------------------
    // shared transceiver owner
    // ------------------------------------------------------------
    // both drivers are parked for the quiet time before the owner flips
    logic               next_owner;
    logic               next_switching;
    logic [QUIET_W-1:0] ownCnt;
    logic [QUIET_W-1:0] next_ownCnt;
    logic [1:0]         next_fs;
    logic [1:0]         next_hs;
    logic               next_oe_n;

    always_comb begin
        next_owner     = deviceOwnsPort;
        next_switching = 1'b0;
        next_ownCnt    = '0;
        if (devPort != deviceOwnsPort) begin
            next_switching = 1'b1;
            next_ownCnt    = ownCnt + QUIET_W'(1);
            if (ownCnt == QUIET_W'(SWITCH_QUIET_CYC - 1)) begin
                next_owner     = devPort;
                next_ownCnt    = '0;
            end
        end
        // only controller lines reach the pins, nothing else may drive them
        if (next_switching) begin
            next_fs   = 2'b00;
            next_hs   = 2'b00;
            next_oe_n = 1'b1;
        end else if (deviceOwnsPort) begin
            next_fs   = deviceFsLine;
            next_hs   = deviceHsLine;
            next_oe_n = ~deviceDrive;
        end else begin
            next_fs   = hostAFsLine;
            next_hs   = hostAHsLine & {2{hsReady}};
            next_oe_n = ~hostADrive;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            deviceOwnsPort <= 1'b0;
            switching      <= 1'b0;
            ownCnt         <= '0;
            xcvrFsOut      <= '0;
            xcvrHsOut      <= '0;
            xcvrOe_n       <= 1'b1;
        end else begin
            deviceOwnsPort <= next_owner;
            switching      <= next_switching;
            ownCnt         <= next_ownCnt;
            xcvrFsOut      <= next_fs;
            xcvrHsOut      <= next_hs;
            xcvrOe_n       <= next_oe_n;
        end
    end

    // ------------------------------------------------------------
    // clock enables and control outputs
    // ------------------------------------------------------------
    logic next_hsTick;
    logic next_irq;

    always_comb begin
        next_hsTick = phyClk30Tick & hsReady;
        next_irq    = ehciIrq | ohciIrq;
    end

    // registered copies keep every output on a flip-flop; costs one cycle
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            hsIfTick        <= 1'b0;
            ohci48mTick     <= 1'b0;
            ohci12mTick     <= 1'b0;
            hostIrq         <= 1'b0;
            utmiPllEnable   <= 1'b0;
            phyBiasEnable   <= 1'b0;
            pllStartupCount <= '0;
            hostPeriphClkEn <= 1'b0;
        end else begin
            hsIfTick        <= next_hsTick;
            ohci48mTick     <= clkLink.tick48;
            ohci12mTick     <= clkLink.tick12;
            hostIrq         <= next_irq;
            utmiPllEnable   <= pllEn;
            phyBiasEnable   <= phy_bias_enable & pllEn;
            pllStartupCount <= ctrl[CTRL_COUNT_LSB +: COUNT_W];
            hostPeriphClkEn <= periphEn;
        end
    end
endmodule
`default_nettype wire

//--- uhc_pll_model.sv
// model of the two plls and the transceiver's returned clock
`timescale 1ns/10ps
`default_nettype none
module uhc_pll_model #(
    parameter int LOCK_CYC = 24
) (
    // clock and reset
    input  wire logic clk_sys,
    input  wire logic reset,
    // controls from the glue
    input  wire logic utmiPllEnable,
    input  wire logic phyBiasEnable,
    // clocks and lock toward the glue
    output logic      utmiPllLockPin,
    output logic      utmiPllTick,
    output logic      systemPllTick,
    output logic      phyClk30Tick
);
    // ----------------------------------------
    // lock after a startup span, clocks as enable pulses
    // ----------------------------------------
    int         lockCnt;
    logic [1:0] phase;
    always @(posedge clk_sys) begin
        if (reset || !utmiPllEnable) begin
            lockCnt        <= 0;
            utmiPllLockPin <= 1'h0;
        end else begin
            lockCnt        <= (lockCnt < LOCK_CYC) ? lockCnt + 1 : lockCnt;
            utmiPllLockPin <= (lockCnt >= LOCK_CYC);
        end
        phase <= reset ? 2'h0 : phase + 2'h1;
    end
    // a stopped pll gives no clock at all, not a frozen one
    assign utmiPllTick   = utmiPllEnable && utmiPllLockPin;
    assign systemPllTick = phase[0];
    // returned clock only while the pll runs and the bias is up
    assign phyClk30Tick  = utmiPllLockPin && phyBiasEnable && (phase == 2'h3);
endmodule
`default_nettype wire

//--- uhc_share_sva.sv
// assertions on the clock and port-sharing glue
`timescale 1ns/10ps
`default_nettype none
module uhc_share_chk (
    // clock and reset
    input wire logic       clk_sys,
    input wire logic       reset,
    // clocks and events
    input wire logic       phyClk30Tick,
    input wire logic       hsIfTick,
    input wire logic       ohci48mTick,
    input wire logic       ohci12mTick,
    input wire logic       hostPeriphClkEn,
    input wire logic       utmiPllEnable,
    input wire logic       phyBiasEnable,
    input wire logic       ehciIrq,
    input wire logic       ohciIrq,
    input wire logic       hostIrq,
    // shared port
    input wire logic [1:0] hostAFsLine,
    input wire logic [1:0] deviceFsLine,
    input wire logic       hostADrive,
    input wire logic       deviceDrive,
    input wire logic [1:0] xcvrFsOut,
    input wire logic       xcvrOe_n,
    input wire logic       deviceOwnsPort
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (reset);
    // ----------------------------------------
    // sequences and properties
    // ----------------------------------------
    sequence s_clk_off;
        !hostPeriphClkEn [*3];
    endsequence
    sequence s_owner_steady;
        $stable(deviceOwnsPort) && !xcvrOe_n;
    endsequence
    AST_HS_IF: assert property (hsIfTick |-> $past(phyClk30Tick))
        else $error("hs tick without returned clock");
    // pll and bias outputs are registered in the same cycle as the tick, so both stand with it
    AST_HS_PLL: assert property (hsIfTick |-> utmiPllEnable && phyBiasEnable)
        else $error("hs tick with pll or bias off");
    AST_SLOW_ON_FAST: assert property (ohci12mTick |-> ohci48mTick)
        else $error("slow tick off a fast tick");
    AST_SLOW_GAP: assert property (ohci12mTick |=> !ohci12mTick [*3])
        else $error("slow ticks too close");
    AST_CLK_OFF: assert property (s_clk_off |-> !ohci48mTick)
        else $error("fast tick with peripheral clock off");
    AST_IRQ: assert property (!$past(reset) |-> hostIrq == $past(ehciIrq || ohciIrq))
        else $error("interrupt line wrong");
    // the owner may only flip behind a quiet, released port
    AST_OWN_QUIET: assert property ($changed(deviceOwnsPort) |->
        $past(xcvrOe_n) && $past(xcvrFsOut) == 2'h0)
        else $error("owner flipped while driving");
    AST_ROUTE: assert property (s_owner_steady |->
        xcvrFsOut == (deviceOwnsPort ? $past(deviceFsLine) : $past(hostAFsLine)))
        else $error("wrong lines routed");
    AST_DRIVE: assert property (!xcvrOe_n |->
        (deviceOwnsPort ? $past(deviceDrive) : $past(hostADrive)))
        else $error("port driven without owner request");
endmodule
bind uhc_clock_phy_share uhc_share_chk chk (.*);
`default_nettype wire

//--- testbench.sv
// self-checking bench for the clock and port-sharing glue
`timescale 1ns/10ps
`default_nettype none
module testbench;
    import uhc_pkg::*;
    typedef struct packed {
        logic [31:0] val;
        logic [31:0] mask;
    } uhc_exp_t;
    // ----------------------------------------
    // signals, design and partner
    // ----------------------------------------
    logic        clk_sys = 1'h0, reset = 1'h1, regWrite = 1'h0, regRead = 1'h0;
    logic [7:0]  regAddr = 8'h00;
    logic [31:0] regWdata = 32'h0000_0000;
    logic        ehciIrq = 1'h0, ohciIrq = 1'h0, hostBusError = 1'h0;
    logic        hostADrive = 1'h0, deviceDrive = 1'h0;
    logic [1:0]  hostAFsLine = 2'h0, hostAHsLine = 2'h0, deviceFsLine = 2'h0, deviceHsLine = 2'h0;
    logic [31:0] regRdata;
    logic [7:0]  pllStartupCount;
    logic        utmiPllLockPin, utmiPllTick, systemPllTick, phyClk30Tick, utmiPllEnable;
    logic        phyBiasEnable, hsIfTick, ohci48mTick, ohci12mTick, hostPeriphClkEn, hostIrq;
    logic [1:0]  xcvrFsOut, xcvrHsOut;
    logic        xcvrOe_n, deviceOwnsPort, rdPend = 1'h0;
    uhc_exp_t    expQ[$];
    uhc_exp_t    cur;
    int          err_total = 0, checks_done = 0, n48 = 0, n12 = 0, nHs = 0, i;
    logic [31:0] v;
    logic [31:0] fsCtrl [5] = '{32'h0000_0011, 32'h0000_0111, 32'h0000_0211,
                                32'h0000_0019, 32'h0000_0001};
    int          fsExp [5] = '{120, 60, 40, 0, 0};
    uhc_clock_phy_share DUT (.*);
    uhc_pll_model       PLL (.*);
    always #5 clk_sys = ~clk_sys;
    // ----------------------------------------
    // tasks
    // ----------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            err_total++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic summarize();
        $display("checks %0d, mismatches %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        regWrite <= 1'h1;
        regAddr  <= a;
        regWdata <= d;
        @(posedge clk_sys);
        regWrite <= 1'h0;
    endtask
    // the expectation is queued here and judged by the read monitor
    task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
        @(posedge clk_sys);
        regRead <= 1'h1;
        regAddr <= a;
        expQ.push_back(uhc_exp_t'{e, m});
        @(posedge clk_sys);
        regRead <= 1'h0;
    endtask
    // counts are exact because the window is a multiple of every period
    task automatic measure(input int e48, input int eHs);
        @(posedge clk_sys);
        n48 = 0;
        n12 = 0;
        nHs = 0;
        repeat (240) @(posedge clk_sys);
        check(n48, e48);
        check(n12, e48 / 4);
        check(nHs, eHs);
    endtask
    // read data stands only in the cycle after the strobe
    always @(posedge clk_sys) begin
        if (rdPend) begin
            cur = expQ.pop_front();
            check(regRdata & cur.mask, cur.val);
        end
        rdPend <= regRead;
    end
    always @(negedge clk_sys) begin
        if (ohci48mTick === 1'h1) n48++;
        if (ohci12mTick === 1'h1) n12++;
        if (hsIfTick === 1'h1) nHs++;
    end
    initial begin
        repeat (20000) @(posedge clk_sys);
        err_total++;
        summarize();
    end
    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        void'($urandom(32'h9e7b));
        repeat (16) @(posedge clk_sys);
        reset <= 1'h0;
        rd(OFF_CTRL, 32'h0000_0000, '1);
        rd(OFF_STATUS, 32'h0000_0000, '1);
        v = $urandom & 32'hFFFF_FFDF;
        wr(OFF_CTRL, v);
        rd(OFF_CTRL, v & 32'h00FF_0F3F, '1);
        @(negedge clk_sys);
        check({hostPeriphClkEn, pllStartupCount}, {v[0], v[23:16]});
        wr(8'h08, 32'hFFFF_FFFF);
        wr(OFF_CTRL, 32'h0000_0000);
        rd(8'h08, 32'h0000_0000, '1);
        rd(OFF_CTRL, 32'h0000_0000, '1);
        // high-speed bring-up in the documented order
        wr(OFF_CTRL, 32'h0000_0001);
        wr(OFF_CTRL, 32'h0010_0003);
        for (i = 0; i < 200 && utmiPllLockPin !== 1'h1; i++) @(posedge clk_sys);
        repeat (6) @(posedge clk_sys);
        rd(OFF_STATUS, 32'h0000_0001, 32'h0000_0003);
        wr(OFF_CTRL, 32'h0010_0007);
        wr(OFF_CTRL, 32'h0010_000F);
        wr(OFF_CTRL, 32'h0010_090F);
        wr(OFF_CTRL, 32'h0010_091F);
        repeat (20) @(posedge clk_sys);
        rd(OFF_STATUS, 32'h0000_0007, 32'h0000_0007);
        measure(24, 60);
        // full-speed only, utmi pll stopped
        for (i = 0; i < 5; i++) begin
            wr(OFF_CTRL, 32'h0000_0001);
            wr(OFF_CTRL, fsCtrl[i] & 32'hFFFF_FFEF);
            wr(OFF_CTRL, fsCtrl[i]);
            repeat (20) @(posedge clk_sys);
            measure(fsExp[i], 0);
        end
        @(posedge clk_sys);
        hostBusError <= 1'h1;
        @(posedge clk_sys);
        hostBusError <= 1'h0;
        rd(OFF_STATUS, 32'h0000_0010, 32'h0000_0010);
        wr(OFF_STATUS, 32'h0000_0010);
        rd(OFF_STATUS, 32'h0000_0000, 32'h0000_0010);
        for (i = 0; i < 4; i++) begin
            @(posedge clk_sys);
            {ehciIrq, ohciIrq} <= 2'(i);
            repeat (2) @(negedge clk_sys);
            check(hostIrq, i != 0);
        end
        // host owns port a; its hs lines stay dark without the pll
        @(posedge clk_sys);
        hostADrive  <= 1'h1;
        hostAFsLine <= 2'($urandom);
        hostAHsLine <= 2'h3;
        repeat (3) @(negedge clk_sys);
        check({xcvrOe_n, xcvrFsOut, xcvrHsOut},
              {1'h0, hostAFsLine, 2'h0});
        wr(OFF_CTRL, 32'h0000_0021);
        repeat (3) @(negedge clk_sys);
        check({xcvrOe_n, xcvrFsOut}, 3'h4);
        rd(OFF_STATUS, 32'h0000_0020, 32'h0000_0028);
        wr(OFF_CTRL, 32'h0000_0001);
        repeat (15) @(negedge clk_sys);
        check(deviceOwnsPort, 1'h0);
        wr(OFF_CTRL, 32'h0000_0021);
        repeat (15) @(posedge clk_sys);
        deviceDrive  <= 1'h1;
        deviceFsLine <= 2'($urandom);
        deviceHsLine <= 2'($urandom);
        repeat (3) @(negedge clk_sys);
        check({deviceOwnsPort, xcvrFsOut, xcvrHsOut},
              {1'h1, deviceFsLine, deviceHsLine});
        rd(OFF_STATUS, 32'h0000_0008, 32'h0000_0028);
        // mid-run reset: port released and owner back to host while it is held
        @(posedge clk_sys);
        reset <= 1'h1;
        repeat (2) @(negedge clk_sys);
        check({xcvrOe_n, deviceOwnsPort, hostPeriphClkEn, ohci48mTick}, 4'h8);
        @(posedge clk_sys);
        reset <= 1'h0;
        rd(OFF_CTRL, 32'h0000_0000, '1);
        rd(OFF_STATUS, 32'h0000_0000, '1);
        repeat (3) @(posedge clk_sys);
        summarize();
    end
endmodule
`default_nettype wire
